// [shared/ufb_pkg.sv]
// Constants, types and decode helpers for the serial frame-format and baud block
`default_nettype none
package ufb_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          AW           = 8;
  localparam logic [7:0]  ADDR_SHARED  = 8'h00;
  localparam logic [7:0]  ADDR_DIV_LOW = 8'h04;
  localparam logic [7:0]  ADDR_CTRL_B  = 8'h08;
  localparam logic [7:0]  ADDR_STAT_A  = 8'h0C;
  localparam logic [7:0]  ADDR_DATA    = 8'h10;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SEL_BIT   = 7;
  localparam int MODE_BIT  = 6;
  localparam int PAR_HI    = 5;
  localparam int PAR_LO    = 4;
  localparam int STOP_BIT  = 3;
  localparam int CSZ_HI    = 2;
  localparam int CSZ_LO    = 1;
  localparam int POL_BIT   = 0;
  localparam int RXEN_BIT  = 4;
  localparam int TXEN_BIT  = 3;
  localparam int CTOP_BIT  = 2;
  localparam int RX9_BIT   = 1;
  localparam int RXC_BIT   = 7;
  localparam int TXRDY_BIT = 5;
  localparam int FE_BIT    = 4;
  localparam int PE_BIT    = 2;
  localparam int DBL_BIT   = 1;
  localparam int DIV_W     = 12;
  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]       FRAME_RST = 8'h86;
  localparam logic [DIV_W-1:0] DIV_RST   = 12'h000;
  localparam logic [4:0]       OS_NORMAL = 5'h10;
  localparam logic [4:0]       OS_DOUBLE = 5'h08;
  localparam logic [1:0]       RESP_OKAY = 2'h0;
  localparam logic [1:0]       RESP_SLVE = 2'h2;
  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef enum logic {TX_IDLE, TX_SHIFT} ufb_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} ufb_rx_state_t;

  function automatic logic [3:0] ufb_char_bits(input logic [2:0] code);
    case (code)
      3'h0: return 4'h5;
      3'h1: return 4'h6;
      3'h2: return 4'h7;
      3'h7: return 4'h9;
      default: return 4'h8;
    endcase
  endfunction

  function automatic logic [8:0] ufb_data_mask(input logic [3:0] n);
    return 9'h1ff >> (4'h9 - n);
  endfunction
endpackage
`default_nettype wire

// [shared/ufb_baud_if.sv]
// Carrier between the register block and the baud prescaler
`default_nettype none
interface ufb_baud_if;
  logic [11:0] divisor;
  logic        reload;
  logic        tick;
  modport ctl (output divisor, output reload, input tick);
  modport gen (input divisor, input reload, output tick);
endinterface
`default_nettype wire

// [rtl/ufb_baud_gen.sv]
// Baud prescaler: one tick every divisor plus one clock cycles
`default_nettype none
module ufb_baud_gen (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic ce,
  ufb_baud_if.gen   bif
);
  logic [11:0] cnt_r;
  logic [11:0] cnt_nxt;
  wire         wrap = (cnt_r == 12'h000);

  // Reload on the low-byte write restarts the period at once
  assign cnt_nxt  = (bif.reload || wrap) ? bif.divisor : cnt_r - 12'h001;
  assign bif.tick = ce && wrap && !bif.reload;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= ufb_pkg::DIV_RST;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

  AST_RELOAD_NOW: assert property (@(posedge sys_clk) disable iff (rst)
    ce && bif.reload |=> cnt_r == $past(bif.divisor))
    else $error("prescaler did not reload on low byte write");
  AST_TICK_PERIOD: assert property (@(posedge sys_clk) disable iff (rst)
    ce && bif.tick && bif.divisor == 12'h001 ##1 ce && !bif.reload |->
    !bif.tick ##1 (bif.tick || !ce || bif.reload))
    else $error("prescaler tick spacing wrong");
endmodule
`default_nettype wire

// [rtl/ufb_top.sv]
// Serial transceiver with frame-format and baud divisor registers on AXI4-Lite
// Contract
// - Shared address; written bit 7 picks register
// - Frame-format read returns select bit one
// - High divisor read returns select bit zero
// - Mode bit picks asynchronous or synchronous operation
// - Parity field: off, reserved, even, odd
// - Transmitter appends computed parity bit
// - Receiver checks parity, flags mismatch
// - Stop-select bit gives one or two stops
// - Receiver ignores stop-select bit
// - Three-bit size code gives five to nine
// - Polarity picks transmit and sample clock edges
// - Divisor is twelve bits, high nibble, low byte
// - Low byte write reloads prescaler immediately
// - Double speed cuts oversampling sixteen to eight
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`default_nettype none
module ufb_top (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rxd,
  input  wire logic        sync_serial_clock,
  output logic             txd
);
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic        aw_have_r, w_have_r, bvalid_r, rvalid_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r, rdata_r;
  logic        w_strb0_r;
  logic [1:0]  bresp_r, rresp_r;
  logic        last_rd_sh_r, rd_was_ff_r, rd_was_hi_r;

  function automatic logic addr_ok(input logic [7:0] a);
    return a == ufb_pkg::ADDR_SHARED || a == ufb_pkg::ADDR_DIV_LOW ||
           a == ufb_pkg::ADDR_CTRL_B || a == ufb_pkg::ADDR_STAT_A ||
           a == ufb_pkg::ADDR_DATA;
  endfunction

  assign s_axi_awready = ce && !aw_have_r && !bvalid_r;
  assign s_axi_wready  = ce && !w_have_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ce && !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  wire wr_go   = ce && aw_have_r && w_have_r && !bvalid_r;
  wire wr_en   = wr_go && w_strb0_r;
  wire wr_sh   = wr_en && aw_addr_r == ufb_pkg::ADDR_SHARED;
  wire wr_ff   = wr_sh && w_data_r[ufb_pkg::SEL_BIT];
  wire wr_hi   = wr_sh && !w_data_r[ufb_pkg::SEL_BIT];
  wire wr_low  = wr_en && aw_addr_r == ufb_pkg::ADDR_DIV_LOW;
  wire wr_ctl  = wr_en && aw_addr_r == ufb_pkg::ADDR_CTRL_B;
  wire wr_stat = wr_en && aw_addr_r == ufb_pkg::ADDR_STAT_A;
  wire wr_data = wr_en && aw_addr_r == ufb_pkg::ADDR_DATA;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_sh   = s_axi_araddr == ufb_pkg::ADDR_SHARED;
  wire rd_ff   = rd_sh && last_rd_sh_r;
  wire rd_dat  = rd_take && s_axi_araddr == ufb_pkg::ADDR_DATA;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb0_r <= 1'b0;
      bresp_r   <= ufb_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r  <= 1'b1;
        w_data_r  <= s_axi_wdata;
        w_strb0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= addr_ok(aw_addr_r) ? ufb_pkg::RESP_OKAY : ufb_pkg::RESP_SLVE;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [6:0] frame_r;
  logic [3:0] div_hi_r;
  logic [7:0] div_lo_r;
  logic       ctop_r, tx_en_r, rx_en_r, dbl_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frame_r  <= ufb_pkg::FRAME_RST[6:0];
      div_hi_r <= ufb_pkg::DIV_RST[11:8];
      div_lo_r <= ufb_pkg::DIV_RST[7:0];
      ctop_r   <= 1'b0;
      tx_en_r  <= 1'b0;
      rx_en_r  <= 1'b0;
      dbl_r    <= 1'b0;
    end else if (ce) begin
      if (wr_ff) frame_r <= w_data_r[6:0];
      if (wr_hi) div_hi_r <= w_data_r[3:0];
      if (wr_low) div_lo_r <= w_data_r[7:0];
      if (wr_ctl) begin
        ctop_r  <= w_data_r[ufb_pkg::CTOP_BIT];
        tx_en_r <= w_data_r[ufb_pkg::TXEN_BIT];
        rx_en_r <= w_data_r[ufb_pkg::RXEN_BIT];
      end
      if (wr_stat) dbl_r <= w_data_r[ufb_pkg::DBL_BIT];
    end
  end

  wire       sync_mode             = frame_r[ufb_pkg::MODE_BIT];
  wire [1:0] parity_mode           = frame_r[ufb_pkg::PAR_HI:ufb_pkg::PAR_LO];
  wire       stop_bit_count_select = frame_r[ufb_pkg::STOP_BIT];
  wire [1:0] char_size_low         = frame_r[ufb_pkg::CSZ_HI:ufb_pkg::CSZ_LO];
  wire       sync_clock_polarity   = frame_r[ufb_pkg::POL_BIT];
  wire       par_en                = parity_mode[1];
  wire       par_odd               = parity_mode[0];
  wire [3:0] nbits = ufb_pkg::ufb_char_bits({ctop_r, char_size_low});
  wire [8:0] dmask = ufb_pkg::ufb_data_mask(nbits);
  wire [4:0] os_len = (dbl_r && !sync_mode) ? ufb_pkg::OS_DOUBLE : ufb_pkg::OS_NORMAL;

  ufb_baud_if bif ();
  assign bif.divisor = {div_hi_r, div_lo_r};
  assign bif.reload  = wr_low;
  ufb_baud_gen u_baud (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .bif     (bif)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers and serial clock edges
  // ----------------------------------------------------------------
  logic rxd_s1_r, rxd_s2_r, xck_s1_r, xck_s2_r, xck_s3_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {rxd_s1_r, rxd_s2_r} <= 2'h3;
      {xck_s1_r, xck_s2_r, xck_s3_r} <= 3'h0;
    end else if (ce) begin
      {rxd_s2_r, rxd_s1_r} <= {rxd_s1_r, rxd};
      {xck_s3_r, xck_s2_r, xck_s1_r} <= {xck_s2_r, xck_s1_r, sync_serial_clock};
    end
  end
  wire xck_rise = xck_s2_r && !xck_s3_r;
  wire xck_fall = !xck_s2_r && xck_s3_r;
  wire tx_edge  = sync_clock_polarity ? xck_fall : xck_rise;
  wire rx_edge  = sync_clock_polarity ? xck_rise : xck_fall;

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  ufb_pkg::ufb_tx_state_t tx_state_r;
  logic [12:0] tx_sh_r;
  logic [3:0]  tx_left_r;
  logic [4:0]  tx_os_r;
  logic [8:0]  tx_buf_r;
  logic        tx_full_r, txd_r;

  wire [8:0]  tx_dat  = tx_buf_r & dmask;
  wire        tx_par  = ^tx_dat ^ par_odd;
  wire [12:0] par_pos = 13'h0001 << (nbits + 4'h1);
  wire [12:0] tx_base = ({13{1'b1}} << (nbits + 4'h1)) | {3'h0, tx_dat, 1'b0};
  wire [12:0] tx_frame = par_en ? ((tx_base & ~par_pos) | (tx_par ? par_pos : 13'h0000))
                                : tx_base;
  wire [3:0]  tx_len  = nbits + 4'h2 + {3'h0, par_en} + {3'h0, stop_bit_count_select};
  wire [12:0] par_span = par_pos | {3'h0, dmask, 1'b0};
  wire tx_ld   = ce && tx_state_r == ufb_pkg::TX_IDLE && tx_full_r && tx_en_r;
  wire tx_wrap = bif.tick && tx_os_r == os_len - 5'h01;
  wire tx_step = sync_mode ? tx_edge : tx_wrap;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_state_r <= ufb_pkg::TX_IDLE;
      tx_sh_r    <= 13'h1fff;
      tx_left_r  <= 4'h0;
      tx_os_r    <= 5'h00;
      tx_buf_r   <= 9'h000;
      tx_full_r  <= 1'b0;
      txd_r      <= 1'b1;
    end else if (ce) begin
      if (wr_data && !tx_full_r) begin
        tx_buf_r  <= w_data_r[8:0];
        tx_full_r <= 1'b1;
      end
      if (bif.tick) tx_os_r <= tx_wrap ? 5'h00 : tx_os_r + 5'h01;
      unique case (tx_state_r)
        ufb_pkg::TX_IDLE: begin
          if (tx_ld) begin
            tx_sh_r    <= tx_frame;
            tx_left_r  <= tx_len;
            tx_os_r    <= 5'h00;
            tx_full_r  <= 1'b0;
            tx_state_r <= ufb_pkg::TX_SHIFT;
          end
        end
        ufb_pkg::TX_SHIFT: begin
          if (tx_step) begin
            if (tx_left_r == 4'h0) begin
              tx_state_r <= ufb_pkg::TX_IDLE;
            end else begin
              txd_r     <= tx_sh_r[0];
              tx_sh_r   <= {1'b1, tx_sh_r[12:1]};
              tx_left_r <= tx_left_r - 4'h1;
            end
          end
        end
      endcase
    end
  end
  assign txd = txd_r;

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  ufb_pkg::ufb_rx_state_t rx_state_r;
  logic [10:0] rx_sh_r;
  logic [3:0]  rx_idx_r;
  logic [4:0]  rx_os_r;
  logic [8:0]  rx_d_r;
  logic        rxc_r, pe_r, fe_r;

  wire [3:0] rx_need = nbits + 4'h1 + {3'h0, par_en};
  wire [4:0] rx_lim  = rx_state_r == ufb_pkg::RX_START ? {1'b0, os_len[4:1]} : os_len;
  wire rx_wrap = bif.tick && rx_os_r == rx_lim - 5'h01;
  wire rx_step = sync_mode ? rx_edge : rx_wrap;
  wire rx_done = ce && rx_state_r == ufb_pkg::RX_BITS && rx_step && rx_idx_r == rx_need - 4'h1;
  wire [8:0] rx_dat = rx_sh_r[8:0] & dmask;
  wire rx_pbad = par_en && (rx_sh_r[nbits] != (^rx_dat ^ par_odd));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_state_r <= ufb_pkg::RX_IDLE;
      rx_sh_r    <= 11'h000;
      rx_idx_r   <= 4'h0;
      rx_os_r    <= 5'h00;
    end else if (ce) begin
      if (bif.tick) rx_os_r <= rx_wrap ? 5'h00 : rx_os_r + 5'h01;
      unique case (rx_state_r)
        ufb_pkg::RX_IDLE: begin
          rx_idx_r <= 4'h0;
          rx_os_r  <= 5'h00;
          if (rx_en_r && !rxd_s2_r && (!sync_mode || rx_edge)) begin
            rx_state_r <= sync_mode ? ufb_pkg::RX_BITS : ufb_pkg::RX_START;
          end
        end
        ufb_pkg::RX_START: begin
          if (rx_wrap) rx_state_r <= rxd_s2_r ? ufb_pkg::RX_IDLE : ufb_pkg::RX_BITS;
        end
        ufb_pkg::RX_BITS: begin
          if (rx_step) begin
            rx_sh_r[rx_idx_r] <= rxd_s2_r;
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_done) rx_state_r <= ufb_pkg::RX_IDLE;
          end
        end
        default: rx_state_r <= ufb_pkg::RX_IDLE;
      endcase
      if (!rx_en_r) rx_state_r <= ufb_pkg::RX_IDLE;
    end
  end

  // New character beats a same-cycle read of the data register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_d_r <= 9'h000;
      rxc_r  <= 1'b0;
      pe_r   <= 1'b0;
      fe_r   <= 1'b0;
    end else if (ce) begin
      rxc_r <= rx_done || (rxc_r && !rd_dat && rx_en_r);
      if (rx_done) begin
        rx_d_r <= rx_dat;
        pe_r   <= rx_pbad;
        fe_r   <= !rxd_s2_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [7:0] rd_shared = rd_ff ? {1'b1, frame_r} : {4'h0, div_hi_r};
  wire [7:0] rd_stat = {rxc_r, 1'b0, !tx_full_r, fe_r, 1'b0, pe_r, dbl_r, 1'b0};
  wire [7:0] rd_ctl  = {3'h0, rx_en_r, tx_en_r, ctop_r, rx_d_r[8], 1'b0};
  wire [31:0] rd_mux =
    s_axi_araddr == ufb_pkg::ADDR_SHARED  ? {24'h00_0000, rd_shared} :
    s_axi_araddr == ufb_pkg::ADDR_DIV_LOW ? {24'h00_0000, div_lo_r}  :
    s_axi_araddr == ufb_pkg::ADDR_CTRL_B  ? {24'h00_0000, rd_ctl}    :
    s_axi_araddr == ufb_pkg::ADDR_STAT_A  ? {24'h00_0000, rd_stat}   :
    s_axi_araddr == ufb_pkg::ADDR_DATA    ? {23'h00_0000, rx_d_r}    : 32'h0000_0000;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rvalid_r     <= 1'b0;
      rdata_r      <= 32'h0000_0000;
      rresp_r      <= ufb_pkg::RESP_OKAY;
      last_rd_sh_r <= 1'b0;
      rd_was_ff_r  <= 1'b0;
      rd_was_hi_r  <= 1'b0;
    end else if (ce) begin
      if (wr_go) last_rd_sh_r <= 1'b0;
      if (rd_take) begin
        rvalid_r     <= 1'b1;
        rdata_r      <= rd_mux;
        rresp_r      <= addr_ok(s_axi_araddr) ? ufb_pkg::RESP_OKAY : ufb_pkg::RESP_SLVE;
        last_rd_sh_r <= rd_sh && !last_rd_sh_r;
        rd_was_ff_r  <= rd_ff;
        rd_was_hi_r  <= rd_sh && !rd_ff;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_SEL_FRAME: assert property (wr_ff |=> frame_r == $past(w_data_r[6:0]) &&
    $stable(div_hi_r)) else $error("frame write went astray");
  AST_SEL_HIGH: assert property (wr_hi |=> div_hi_r == $past(w_data_r[3:0]) &&
    $stable(frame_r)) else $error("high divisor write went astray");
  AST_FF_READ_ONE: assert property (rvalid_r && rd_was_ff_r |-> rdata_r[7])
    else $error("frame read lacks select bit");
  AST_HI_READ_ZERO: assert property (rvalid_r && rd_was_hi_r |-> rdata_r[7:4] == 4'h0)
    else $error("high divisor read shows upper bits");
  AST_TX_PARITY: assert property (tx_ld && par_en |=>
    (^(tx_sh_r & $past(par_span))) == $past(par_odd)) else $error("parity bit wrong");
  AST_TX_STOPS: assert property (tx_ld && !par_en |=>
    tx_left_r == $past(nbits) + 4'h2 + {3'h0, $past(stop_bit_count_select)})
    else $error("stop bit count wrong");
  AST_RX_NO_PAR: assert property (rx_done && parity_mode != 2'h2 && parity_mode != 2'h3
    |=> !pe_r) else $error("parity error with parity off");
  AST_RX_NEED: assert property (rx_done |->
    rx_idx_r == nbits + {3'h0, par_en}) else $error("receiver frame length wrong");
  AST_CSZ_NINE: assert property ({ctop_r, char_size_low} == 3'h7 |-> nbits == 4'h9)
    else $error("nine bit size not decoded");
  AST_SYNC_EDGE: assert property (sync_mode && !tx_edge |=> $stable(txd_r))
    else $error("sync transmit changed off edge");
  AST_ASYNC_PACE: assert property (!sync_mode && !bif.tick |=> $stable(txd_r))
    else $error("async transmit changed without tick");
  AST_RXC_SET: assert property (rx_done |=> rxc_r) else $error("receive flag lost");
endmodule
`default_nettype wire

// [bench/ufb_peer.sv]
// Remote serial peer: captures frames from txd and sends frames on rxd
`default_nettype none
module ufb_peer #(
  parameter int BIT = 32
) (
  input  wire logic       sys_clk,
  input  wire logic       txd,
  output var logic        rxd,
  output var logic        stb,
  output var logic [9:0]  got
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Sender: start, nine bits LSB first, one stop
  // ----------------------------------------------------------------
  task automatic send(input logic [8:0] f);
    rxd <= 1'b0;
    repeat (BIT) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge sys_clk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge sys_clk);
  endtask

  // Capture: ten bits after the start bit, sampled mid-bit
  initial begin
    rxd = 1'b1;
    stb = 1'b0;
    got = '0;
    forever begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge sys_clk);
      for (int i = 0; i < 10; i++) begin
        repeat (BIT) @(posedge sys_clk);
        got[i] = txd;
      end
      stb <= 1'b1;
      @(posedge sys_clk);
      stb <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [bench/ufb_top_bench.sv]
// Self-checking bench for the frame-format and baud block
`default_nettype none
module ufb_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, rxd, txd, stb, p;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, d;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [9:0]  got;
  logic [67:0] q[$];
  logic [67:0] ent;
  logic [33:0] seen;
  int          fail_count, check_count, cyc;

  ufb_top uut (.sys_clk, .rst, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd,
    .sync_serial_clock(1'b0), .txd);
  ufb_peer #(.BIT(32)) u_peer (.sys_clk, .txd, .rxd, .stb, .got);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // Bus master tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
    @(posedge sys_clk);
    q.push_back({m, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  // Result watcher: oldest note against each read or captured frame
  always @(posedge sys_clk) begin
    if ((s_axi_rvalid && s_axi_rready) || stb) begin
      ent = q.pop_front();
      seen = stb ? {24'h00_0000, got} : {s_axi_rresp, s_axi_rdata};
      check_count++;
      if ((seen & ent[67:34]) !== ent[33:0]) begin
        fail_count++;
        $display("unexpected %s exp %h got %h", stb ? "frame" : "read", ent[33:0],
                 seen & ent[67:34]);
      end
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    void'($urandom(32'h33d5));
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ufb_pkg::ADDR_SHARED, 34'h0, 34'h3_ffff_ffff);
    rd(ufb_pkg::ADDR_SHARED, 34'h0_0000_0086, 34'h3_ffff_ffff);
    wr(ufb_pkg::ADDR_SHARED, 32'h0000_0005);
    wr(ufb_pkg::ADDR_SHARED, 32'h0000_00ae);
    rd(ufb_pkg::ADDR_SHARED, 34'h0_0000_0005, 34'h3_ffff_ffff);
    rd(ufb_pkg::ADDR_SHARED, 34'h0_0000_00ae, 34'h3_ffff_ffff);
    rd(8'h14, {ufb_pkg::RESP_SLVE, 32'h0000_0000}, 34'h3_ffff_ffff);
    wr(ufb_pkg::ADDR_SHARED, 32'h0000_0000);
    wr(ufb_pkg::ADDR_DIV_LOW, 32'h0000_0001);
    wr(ufb_pkg::ADDR_CTRL_B, 32'h0000_0018);
    for (int m = 0; m < 4; m++) begin
      wr(ufb_pkg::ADDR_SHARED, 32'h0000_008e | 32'(m << 4));
      d = 8'($urandom);
      p = m[1] ? (^d ^ m[0]) : 1'b1;
      q.push_back({34'h3_ffff_ffff, 24'h00_0000, 1'b1, p, d});
      wr(ufb_pkg::ADDR_DATA, {24'h00_0000, d});
      while (!stb) @(posedge sys_clk);
    end
    for (int i = 0; i < 3; i++) begin
      wr(ufb_pkg::ADDR_SHARED, i[1] ? 32'h0000_0086 : 32'h0000_00ae);
      d = 8'($urandom);
      u_peer.send({i[1] ? 1'b1 : (^d ^ i[0]), d});
      do rd(ufb_pkg::ADDR_STAT_A, 34'h0, 34'h0); while (!rdat[7]);
      rd(ufb_pkg::ADDR_STAT_A, {2'h0, 32'h0000_0080 | (32'(i[0]) << 2)}, 34'h3_0000_0084);
      rd(ufb_pkg::ADDR_DATA, {26'h000_0000, d}, 34'h3_0000_00ff);
    end
    end_sim();
  end
endmodule
`default_nettype wire
